//--- verilog/rtcr_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the counter block
// Assumes: Register index times four gives the byte address on the register bus
// Notes: Definitions only; included by the top module and the bench
`ifndef RTCR_REGS_SVH
`define RTCR_REGS_SVH

// Register indices, byte address is index * 4
`define RTCR_IDX_CTRL 5'h00
`define RTCR_IDX_STATUS 5'h01
`define RTCR_IDX_IRQEN 5'h02
`define RTCR_IDX_IRQFL 5'h03
`define RTCR_IDX_LATCH 5'h04
`define RTCR_IDX_DBG 5'h05
`define RTCR_IDX_CRYSTAL_CALIBRATION 5'h06
`define RTCR_IDX_CLOCK_SOURCE_SELECT 5'h07
`define RTCR_IDX_CNT_L 5'h08
`define RTCR_IDX_CNT_H 5'h09
`define RTCR_IDX_TOP_L 5'h0A
`define RTCR_IDX_TOP_H 5'h0B
`define RTCR_IDX_CMP_L 5'h0C
`define RTCR_IDX_CMP_H 5'h0D
`define RTCR_IDX_PCTRL 5'h10
`define RTCR_IDX_PSTAT 5'h11
`define RTCR_IDX_PIRQEN 5'h12
`define RTCR_IDX_PIRQFL 5'h13
`define RTCR_IDX_PDBG 5'h15
`define RTCR_IDX_EVSEL 5'h16

// Control fields
`define RTCR_CTRL_EN 0
`define RTCR_CTRL_CORR 2
`define RTCR_CTRL_PSC_LSB 3
`define RTCR_CTRL_PSC_MSB 6
`define RTCR_CTRL_STBY 7
`define RTCR_CTRL_WMASK 8'hFD
`define RTCR_PCTRL_WMASK 8'h79

// Busy slots: control, count, top, compare
`define RTCR_SLOT_CTRL 0
`define RTCR_SLOT_CNT 1
`define RTCR_SLOT_TOP 2
`define RTCR_SLOT_CMP 3

// Interrupt flag and enable bits
`define RTCR_IRQ_WRAP 0
`define RTCR_IRQ_CMP 1

// Reset values
`define RTCR_TOP_RESET 16'hFFFF
`define RTCR_ZERO_RESET 8'h00

// Timing
`define RTCR_CLK_HZ 40000000
`define RTCR_SLOW_HZ 32768
`define RTCR_SYNC_SLOW_CYCLES 2'h2
`define RTCR_CORR_WINDOW_M1 20'hF_423F

// Bus responses
`define RTCR_RESP_OKAY 2'h0
`define RTCR_RESP_SLVERR 2'h2

`endif

//--- verilog/rtcr_pkg.sv
// Purpose: Types shared by the counter block and its bench
// Assumes: Constants come from rtcr_regs.svh
// Notes: Bus carried as two packed structs, request and response
package rtcr_pkg;

   // Master to slave signals of the register bus
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } rtcr_axi_req_type;

   // Slave to master signals of the register bus
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } rtcr_axi_rsp_type;

   // Complete state of the block
   typedef struct packed {
      logic [15:0] div_cnt;
      logic stby_meta;
      logic stby_sync;
      logic [7:0] ctrl;
      logic [7:0] ctrl_eff;
      logic [1:0] irq_en;
      logic [1:0] irq_flags;
      logic [7:0] latch;
      logic dbg;
      logic [7:0] crystal_calibration;
      logic [1:0] clock_source_select;
      logic [7:0] pctrl;
      logic pirq_en;
      logic pirq_flag;
      logic pdbg;
      logic [7:0] evsel;
      logic [15:0] count;
      logic [15:0] cnt_pend;
      logic [15:0] top_sw;
      logic [15:0] top_eff;
      logic [15:0] cmp_sw;
      logic [15:0] cmp_eff;
      logic [3:0] busy;
      logic [3:0][1:0] sync_cnt;
      logic [14:0] psc;
      logic [19:0] corr_win;
      logic [6:0] corr_done;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } rtcr_state_type;

endpackage : rtcr_pkg

//--- verilog/rtcr_top.sv
// Purpose: 16-bit real-time counter with periodic timer, registers over AXI4-Lite
// Assumes: Slow counter clock is a one-cycle enable derived from clk_i
// Notes: Writes to control, count, top and compare cross after two slow ticks
// Function
// - The prescaler code in control bits 6 to 3 divides the slow clock by two to its power.
// - Control bit 7 set keeps the counter running in standby, clear stops it there.
// - Control bit 2 turns crystal frequency correction of the prescaler on or off.
// - Control bit 0 enables the counter; clearing it holds the count where it is.
// - A control write takes effect in the counter domain after two slow clock cycles.
// - Status bits 3 to 0 read one while compare, top, count or control is synchronising.
// - Interrupt enable bit 1 gates the compare match interrupt.
// - Interrupt enable bit 0 gates the wrap interrupt.
// - Flag bit 1 sets when a count step makes the count equal to the compare value; a count write does not set it.
// - Flag bit 0 sets when the count reached the top value and wrapped to zero.
// - Writing one to a flag clears it, writing zero leaves it.
// - One shared byte latch, readable and writable, serves all 16-bit registers.
// - An interrupt request stands while a flag and its enable are both set.
// - The prescaler runs while the counter or the periodic timer is enabled.
`timescale 1ns/100ps
`include "rtcr_regs.svh"

module rtcr_top #(
   parameter int unsigned SLOW_DIV = `RTCR_CLK_HZ / `RTCR_SLOW_HZ
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire rtcr_pkg::rtcr_axi_req_type axi_req_i,
   output rtcr_pkg::rtcr_axi_rsp_type axi_rsp_o,
   input wire logic standby_i,
   output logic irq_o,
   output logic pit_irq_o
);

   // Divider counter is 16 bits wide
   if (SLOW_DIV < 1 || SLOW_DIV > 65535) begin : g_bad_div
      $error("SLOW_DIV out of range");
   end

   rtcr_pkg::rtcr_state_type st_reg;
   rtcr_pkg::rtcr_state_type st_next;

   logic slow_tick;
   logic aw_rdy;
   logic w_rdy;
   logic ar_rdy;
   logic wr_go;
   logic wr_en;
   logic rd_en;
   logic [4:0] wr_idx;
   logic [4:0] rd_idx;
   logic [7:0] wd;
   logic [7:0] rd_byte;
   logic [3:0] start;
   logic [3:0] apply;
   logic [1:0] clr;
   logic pclr;
   logic psc_run;
   logic corr_act;
   logic corr_adj;
   logic [1:0] step;
   logic cnt_tick;
   logic stby_halt;
   logic [15:0] cnt_new;
   logic wrap_set;
   logic cmp_set;
   logic pit_set;

   // Aligned, in range, and not a reserved hole
   function automatic logic addr_ok(input logic [7:0] a);
      logic [4:0] i;
      i = a[6:2];
      addr_ok = (a[1:0] == 2'h0) && !a[7] && (i <= `RTCR_IDX_EVSEL) &&
                (i != 5'h0E) && (i != 5'h0F) && (i != 5'h14);
   endfunction : addr_ok

   // True when a prescaler step carries out of the low code bits
   function automatic logic psc_carry(input logic [14:0] p, input logic [1:0] s,
                                      input logic [3:0] c);
      logic [15:0] mask;
      logic [15:0] low;
      mask = (16'h0001 << c) - 16'h0001;
      low = {1'b0, p} & mask;
      psc_carry = (s != 2'h0) && ((low + {14'h0000, s}) > mask);
   endfunction : psc_carry

   // Bus handshakes; one request of each kind at a time
   assign aw_rdy = !st_reg.aw_held && !st_reg.bvalid;
   assign w_rdy = !st_reg.w_held && !st_reg.bvalid;
   assign ar_rdy = !st_reg.rvalid;
   assign wr_go = st_reg.aw_held && st_reg.w_held;
   assign wr_en = wr_go && addr_ok(st_reg.aw_addr) && st_reg.wstrb0;
   assign wr_idx = st_reg.aw_addr[6:2];
   assign wd = st_reg.wdata;
   assign rd_en = axi_req_i.arvalid && ar_rdy && addr_ok(axi_req_i.araddr);
   assign rd_idx = axi_req_i.araddr[6:2];

   // Response channel, all from flip-flops except the readies
   assign axi_rsp_o.awready = aw_rdy;
   assign axi_rsp_o.wready = w_rdy;
   assign axi_rsp_o.bvalid = st_reg.bvalid;
   assign axi_rsp_o.bresp = st_reg.bresp;
   assign axi_rsp_o.arready = ar_rdy;
   assign axi_rsp_o.rvalid = st_reg.rvalid;
   assign axi_rsp_o.rdata = st_reg.rdata;
   assign axi_rsp_o.rresp = st_reg.rresp;

   // Request lines stay high until the flag or its enable is cleared
   assign irq_o = |(st_reg.irq_flags & st_reg.irq_en);
   assign pit_irq_o = st_reg.pirq_flag && st_reg.pirq_en;

   // Next state of the whole block
   always_comb begin
      st_next = st_reg;
      start = 4'h0;
      apply = 4'h0;
      clr = 2'h0;
      pclr = 1'b0;
      rd_byte = 8'h00;
      cnt_new = st_reg.count;
      wrap_set = 1'b0;
      cmp_set = 1'b0;

      // Slow counter clock as an enable pulse
      slow_tick = (st_reg.div_cnt == 16'h0000);
      st_next.div_cnt = slow_tick ? 16'(SLOW_DIV - 1) : st_reg.div_cnt - 16'h0001;
      st_next.stby_meta = standby_i;
      st_next.stby_sync = st_reg.stby_meta;

      // Address and data may arrive in either order
      if (axi_req_i.awvalid && aw_rdy) begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = axi_req_i.awaddr;
      end
      if (axi_req_i.wvalid && w_rdy) begin
         st_next.w_held = 1'b1;
         st_next.wdata = axi_req_i.wdata[7:0];
         st_next.wstrb0 = axi_req_i.wstrb[0];
      end
      if (st_reg.bvalid && axi_req_i.bready) begin
         st_next.bvalid = 1'b0;
      end
      if (wr_go) begin
         st_next.aw_held = 1'b0;
         st_next.w_held = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = addr_ok(st_reg.aw_addr) ? `RTCR_RESP_OKAY : `RTCR_RESP_SLVERR;
      end

      // Read decode; low byte reads load the latch with the high byte
      if (rd_idx == `RTCR_IDX_CTRL) begin
         rd_byte = st_reg.ctrl;
      end else if (rd_idx == `RTCR_IDX_STATUS) begin
         rd_byte = {4'h0, st_reg.busy};
      end else if (rd_idx == `RTCR_IDX_IRQEN) begin
         rd_byte = {6'h00, st_reg.irq_en};
      end else if (rd_idx == `RTCR_IDX_IRQFL) begin
         rd_byte = {6'h00, st_reg.irq_flags};
      end else if (rd_idx == `RTCR_IDX_LATCH) begin
         rd_byte = st_reg.latch;
      end else if (rd_idx == `RTCR_IDX_DBG) begin
         rd_byte = {7'h00, st_reg.dbg};
      end else if (rd_idx == `RTCR_IDX_CRYSTAL_CALIBRATION) begin
         rd_byte = st_reg.crystal_calibration;
      end else if (rd_idx == `RTCR_IDX_CLOCK_SOURCE_SELECT) begin
         rd_byte = {6'h00, st_reg.clock_source_select};
      end else if (rd_idx == `RTCR_IDX_CNT_L) begin
         rd_byte = st_reg.count[7:0];
         if (rd_en) st_next.latch = st_reg.count[15:8];
      end else if (rd_idx == `RTCR_IDX_TOP_L) begin
         rd_byte = st_reg.top_sw[7:0];
         if (rd_en) st_next.latch = st_reg.top_sw[15:8];
      end else if (rd_idx == `RTCR_IDX_CMP_L) begin
         rd_byte = st_reg.cmp_sw[7:0];
         if (rd_en) st_next.latch = st_reg.cmp_sw[15:8];
      end else if (rd_idx == `RTCR_IDX_CNT_H || rd_idx == `RTCR_IDX_TOP_H ||
                   rd_idx == `RTCR_IDX_CMP_H) begin
         rd_byte = st_reg.latch;
      end else if (rd_idx == `RTCR_IDX_PCTRL) begin
         rd_byte = st_reg.pctrl;
      end else if (rd_idx == `RTCR_IDX_PIRQEN) begin
         rd_byte = {7'h00, st_reg.pirq_en};
      end else if (rd_idx == `RTCR_IDX_PIRQFL) begin
         rd_byte = {7'h00, st_reg.pirq_flag};
      end else if (rd_idx == `RTCR_IDX_PDBG) begin
         rd_byte = {7'h00, st_reg.pdbg};
      end else if (rd_idx == `RTCR_IDX_EVSEL) begin
         rd_byte = st_reg.evsel;
      end else begin
         rd_byte = 8'h00;
      end
      if (st_reg.rvalid && axi_req_i.rready) begin
         st_next.rvalid = 1'b0;
      end
      if (axi_req_i.arvalid && ar_rdy) begin
         st_next.rvalid = 1'b1;
         st_next.rdata = rd_en ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         st_next.rresp = rd_en ? `RTCR_RESP_OKAY : `RTCR_RESP_SLVERR;
      end

      // Write decode; a write overrides a latch load from a read
      if (wr_en) begin
         if (wr_idx == `RTCR_IDX_CTRL) begin
            st_next.ctrl = wd & `RTCR_CTRL_WMASK;
            start[`RTCR_SLOT_CTRL] = 1'b1;
         end else if (wr_idx == `RTCR_IDX_IRQEN) begin
            st_next.irq_en = wd[1:0];
         end else if (wr_idx == `RTCR_IDX_IRQFL) begin
            clr = wd[1:0];
         end else if (wr_idx == `RTCR_IDX_LATCH) begin
            st_next.latch = wd;
         end else if (wr_idx == `RTCR_IDX_DBG) begin
            st_next.dbg = wd[0];
         end else if (wr_idx == `RTCR_IDX_CRYSTAL_CALIBRATION) begin
            st_next.crystal_calibration = wd;
         end else if (wr_idx == `RTCR_IDX_CLOCK_SOURCE_SELECT) begin
            st_next.clock_source_select = wd[1:0];
         end else if (wr_idx == `RTCR_IDX_CNT_L) begin
            st_next.cnt_pend = {st_reg.latch, wd};
            start[`RTCR_SLOT_CNT] = 1'b1;
         end else if (wr_idx == `RTCR_IDX_TOP_L) begin
            st_next.top_sw = {st_reg.latch, wd};
            start[`RTCR_SLOT_TOP] = 1'b1;
         end else if (wr_idx == `RTCR_IDX_CMP_L) begin
            st_next.cmp_sw = {st_reg.latch, wd};
            start[`RTCR_SLOT_CMP] = 1'b1;
         end else if (wr_idx == `RTCR_IDX_CNT_H || wr_idx == `RTCR_IDX_TOP_H ||
                      wr_idx == `RTCR_IDX_CMP_H) begin
            st_next.latch = wd;
         end else if (wr_idx == `RTCR_IDX_PCTRL) begin
            st_next.pctrl = wd & `RTCR_PCTRL_WMASK;
         end else if (wr_idx == `RTCR_IDX_PIRQEN) begin
            st_next.pirq_en = wd[0];
         end else if (wr_idx == `RTCR_IDX_PIRQFL) begin
            pclr = wd[0];
         end else if (wr_idx == `RTCR_IDX_PDBG) begin
            st_next.pdbg = wd[0];
         end else if (wr_idx == `RTCR_IDX_EVSEL) begin
            st_next.evsel = wd;
         end
      end

      // Crossing slots; a new write restarts its slot, so it never gets lost
      for (int i = 0; i < 4; i++) begin
         if (start[i]) begin
            st_next.busy[i] = 1'b1;
            st_next.sync_cnt[i] = `RTCR_SYNC_SLOW_CYCLES;
         end else if (slow_tick && st_reg.busy[i]) begin
            if (st_reg.sync_cnt[i] == 2'h1) begin
               st_next.busy[i] = 1'b0;
               apply[i] = 1'b1;
            end else begin
               st_next.sync_cnt[i] = st_reg.sync_cnt[i] - 2'h1;
            end
         end
      end
      if (apply[`RTCR_SLOT_CTRL]) st_next.ctrl_eff = st_reg.ctrl;
      if (apply[`RTCR_SLOT_TOP]) st_next.top_eff = st_reg.top_sw;
      if (apply[`RTCR_SLOT_CMP]) st_next.cmp_eff = st_reg.cmp_sw;

      // Prescaler runs for either function; correction bends its step
      psc_run = st_reg.ctrl_eff[`RTCR_CTRL_EN] | st_reg.pctrl[0];
      corr_act = st_reg.ctrl_eff[`RTCR_CTRL_CORR] && slow_tick && psc_run;
      corr_adj = corr_act && (st_reg.corr_done < st_reg.crystal_calibration[6:0]);
      if (!slow_tick || !psc_run) begin
         step = 2'h0;
      end else if (corr_adj) begin
         step = st_reg.crystal_calibration[7] ? 2'h2 : 2'h0;
      end else begin
         step = 2'h1;
      end
      if (corr_act) begin
         st_next.corr_win = (st_reg.corr_win == `RTCR_CORR_WINDOW_M1) ? 20'h0_0000 :
                            st_reg.corr_win + 20'h0_0001;
         if (st_reg.corr_win == `RTCR_CORR_WINDOW_M1) begin
            st_next.corr_done = 7'h00;
         end else if (corr_adj) begin
            st_next.corr_done = st_reg.corr_done + 7'h01;
         end
      end
      st_next.psc = st_reg.psc + {13'h0000, step};

      // Counting; standby halts it unless run in standby is set
      stby_halt = st_reg.stby_sync && !st_reg.ctrl_eff[`RTCR_CTRL_STBY];
      cnt_tick = st_reg.ctrl_eff[`RTCR_CTRL_EN] && !stby_halt &&
                 psc_carry(st_reg.psc, step,
                           st_reg.ctrl_eff[`RTCR_CTRL_PSC_MSB:`RTCR_CTRL_PSC_LSB]);
      if (apply[`RTCR_SLOT_CNT]) begin
         cnt_new = st_reg.cnt_pend;
      end else if (cnt_tick) begin
         if (st_reg.count == st_reg.top_eff) begin
            cnt_new = 16'h0000;
            wrap_set = 1'b1;
         end else begin
            cnt_new = st_reg.count + 16'h0001;
         end
         cmp_set = (cnt_new == st_reg.cmp_eff);
      end
      st_next.count = cnt_new;

      // Periodic timer flag on a rising prescaler bit
      pit_set = st_reg.pctrl[0] && (st_reg.pctrl[6:3] != 4'h0) &&
                (st_reg.pctrl[6:3] != 4'hF) &&
                !st_reg.psc[st_reg.pctrl[6:3]] && st_next.psc[st_reg.pctrl[6:3]];

      // Hardware set wins over a same-cycle clear
      st_next.irq_flags = (st_reg.irq_flags & ~clr) | {cmp_set, wrap_set};
      st_next.pirq_flag = (st_reg.pirq_flag & ~pclr) | pit_set;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_reg <= '0;
         st_reg.top_sw <= `RTCR_TOP_RESET;
         st_reg.top_eff <= `RTCR_TOP_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_psc_stop;
      !st_reg.ctrl_eff[`RTCR_CTRL_EN] && !st_reg.pctrl[0] |=> $stable(st_reg.psc);
   endproperty
   a_psc_stop: assert property (p_psc_stop) else $error("prescaler moved while off");

   property p_div1_count;
      slow_tick && st_reg.ctrl_eff[`RTCR_CTRL_EN] && !st_reg.ctrl_eff[`RTCR_CTRL_CORR] &&
      st_reg.ctrl_eff[6:3] == 4'h0 && !st_reg.stby_sync && !st_reg.busy[1] &&
      st_reg.count != st_reg.top_eff |=> st_reg.count == $past(st_reg.count) + 16'h0001;
   endproperty
   a_div1_count: assert property (p_div1_count) else $error("divide by one missed a count");

   property p_stby_hold;
      st_reg.stby_sync && !st_reg.ctrl_eff[`RTCR_CTRL_STBY] && !st_reg.busy[1]
      |=> $stable(st_reg.count);
   endproperty
   a_stby_hold: assert property (p_stby_hold) else $error("count moved in standby");

   property p_corr_off;
      slow_tick && !st_reg.ctrl_eff[`RTCR_CTRL_CORR] && st_reg.ctrl_eff[`RTCR_CTRL_EN]
      |=> st_reg.psc == $past(st_reg.psc) + 15'h0001;
   endproperty
   a_corr_off: assert property (p_corr_off) else $error("step bent without correction");

   property p_disabled_hold;
      !st_reg.ctrl_eff[`RTCR_CTRL_EN] && !st_reg.busy[1] |=> $stable(st_reg.count);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold) else $error("count moved off");

   property p_ctrl_late;
      $fell(st_reg.busy[0]) |-> st_reg.ctrl_eff == st_reg.ctrl && $past(slow_tick);
   endproperty
   a_ctrl_late: assert property (p_ctrl_late) else $error("control applied badly");

   property p_busy_rise;
      wr_en && wr_idx == `RTCR_IDX_CTRL |=> st_reg.busy[0] ##0
      (st_reg.sync_cnt[0] == 2'h2);
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("control busy not raised");

   property p_irq_gate;
      !(st_reg.irq_en[1] && st_reg.irq_flags[1]) && !(st_reg.irq_en[0] && st_reg.irq_flags[0])
      |-> !irq_o;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request without enable");

   property p_cmp_flag;
      cmp_set |=> st_reg.irq_flags[1] && st_reg.count == st_reg.cmp_eff;
   endproperty
   a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag missing");

   property p_wrap_flag;
      cnt_tick && !apply[1] && st_reg.count == st_reg.top_eff
      |=> st_reg.irq_flags[0] && st_reg.count == 16'h0000;
   endproperty
   a_wrap_flag: assert property (p_wrap_flag) else $error("wrap flag missing");

   property p_w1c;
      wr_en && wr_idx == `RTCR_IDX_IRQFL && wd[0] && !wrap_set |=> !st_reg.irq_flags[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared");

   property p_latch_load;
      rd_en && rd_idx == `RTCR_IDX_CNT_L && !wr_en |=> st_reg.latch == $past(st_reg.count[15:8]);
   endproperty
   a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

   property p_irq_holds;
      irq_o && !(wr_en && wr_idx == `RTCR_IDX_IRQFL) && !(wr_en && wr_idx == `RTCR_IDX_IRQEN)
      |=> irq_o;
   endproperty
   a_irq_holds: assert property (p_irq_holds) else $error("request dropped early");

   c_wrap: cover property (wrap_set);
   c_cmp: cover property (cmp_set ##1 irq_o);
   // Last slow tick of a control crossing, counted by its own slot counter
   c_ctrl_sync: cover property (st_reg.busy[0] && st_reg.sync_cnt[0] == 2'h1 && apply[0]);
   c_pit: cover property (pit_set);

endmodule : rtcr_top

//--- dv/test_rtcr_top.sv
// Purpose: Self-checking bench for the real-time counter register block
// Assumes: Slow tick shortened to eight clock cycles
// Notes: One bus access at a time; answers sampled on the falling edge before the taking edge
`timescale 1ns/100ps
`include "rtcr_regs.svh"

module test_rtcr_top;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic standby_i = 1'b0;
   logic irq_o;
   logic pit_irq_o;
   rtcr_pkg::rtcr_axi_req_type req = '0;
   rtcr_pkg::rtcr_axi_rsp_type rsp;
   int err_total = 0;
   int samples_checked = 0;
   logic [1:0] resp;
   logic [7:0] rv;

   rtcr_top #(.SLOW_DIV(8)) rtcr_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .axi_req_i(req), .axi_rsp_o(rsp), .standby_i(standby_i), .irq_o(irq_o),
      .pit_irq_o(pit_irq_o));

   // 40 MHz clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   // Count steps vary by one with the bus phase
   task automatic chk_step(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp && got !== exp + 16'h0001 && got !== exp - 16'h0001) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_step

   task automatic tmo(inout int n, input int lim);
      n++;
      if (n > lim) begin
         err_total++;
         $display("BAD wait expected answer seen timeout");
         conclude();
      end
   endtask : tmo

   // One access; each valid drops at its own taking edge, the master waits at most 60 cycles
   task automatic acc(input logic wr, input logic [4:0] idx, input logic [7:0] d);
      int n;
      logic aw, w, ar, fin;
      n = 0;
      fin = 1'b0;
      req.awvalid <= wr;
      req.wvalid <= wr;
      req.bready <= wr;
      req.arvalid <= !wr;
      req.rready <= !wr;
      req.awaddr <= {1'b0, idx, 2'b00};
      req.araddr <= {1'b0, idx, 2'b00};
      req.wdata <= {24'h00_0000, d};
      req.wstrb <= 4'h1;
      while (!fin) begin
         @(negedge clk_i);
         tmo(n, 60);
         aw = req.awvalid && rsp.awready;
         w = req.wvalid && rsp.wready;
         ar = req.arvalid && rsp.arready;
         fin = (req.bready && rsp.bvalid) || (req.rready && rsp.rvalid);
         resp = wr ? rsp.bresp : rsp.rresp;
         rv = rsp.rdata[7:0];
         @(posedge clk_i);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
         if (ar) req.arvalid <= 1'b0;
      end
      req.bready <= 1'b0;
      req.rready <= 1'b0;
      // Extra edge so no strobe is assigned twice in one step
      @(posedge clk_i);
   endtask : acc

   task automatic rd16(input logic [4:0] idx, output logic [15:0] v);
      acc(1'b0, idx, 8'h00);
      v[7:0] = rv;
      acc(1'b0, idx + 5'h01, 8'h00);
      v[15:8] = rv;
   endtask : rd16

   task automatic wait_idle(input logic [7:0] mask);
      int k;
      k = 0;
      acc(1'b0, `RTCR_IDX_STATUS, 8'h00);
      while ((rv & mask) !== 8'h00) begin
         tmo(k, 20);
         acc(1'b0, `RTCR_IDX_STATUS, 8'h00);
      end
   endtask : wait_idle

   task automatic t_reset();
      acc(1'b0, `RTCR_IDX_CTRL, 8'h00);
      chk8("control", 8'h00, rv);
      acc(1'b0, `RTCR_IDX_STATUS, 8'h00);
      chk8("status", 8'h00, rv);
      acc(1'b0, `RTCR_IDX_IRQFL, 8'h00);
      chk8("flags", 8'h00, rv);
      acc(1'b0, `RTCR_IDX_TOP_L, 8'h00);
      chk8("top low", 8'hFF, rv);
      acc(1'b0, `RTCR_IDX_LATCH, 8'h00);
      chk8("latch after low read", 8'hFF, rv);
      acc(1'b0, 5'h0E, 8'h00);
      chk8("reserved resp", {6'h00, `RTCR_RESP_SLVERR}, {6'h00, resp});
      $display("t_reset done");
   endtask : t_reset

   task automatic t_ctrl();
      acc(1'b1, `RTCR_IDX_CTRL, 8'h87);
      acc(1'b0, `RTCR_IDX_STATUS, 8'h00);
      chk8("control busy", 8'h01, rv & 8'h0F);
      wait_idle(8'h01);
      acc(1'b0, `RTCR_IDX_CTRL, 8'h00);
      chk8("control", 8'h85, rv);
      acc(1'b1, `RTCR_IDX_LATCH, 8'h5A);
      acc(1'b0, `RTCR_IDX_LATCH, 8'h00);
      chk8("latch", 8'h5A, rv);
      $display("t_ctrl done");
   endtask : t_ctrl

   // Count advance over a fixed window for one control setting
   task automatic measure(input logic [7:0] c, input logic s, input logic [15:0] exp);
      logic [15:0] a, b;
      standby_i <= s;
      acc(1'b1, `RTCR_IDX_CTRL, c);
      wait_idle(8'h01);
      rd16(`RTCR_IDX_CNT_L, a);
      repeat (256) @(posedge clk_i);
      rd16(`RTCR_IDX_CNT_L, b);
      chk_step("count step", exp, b - a);
      $display("measure %h done", c);
   endtask : measure

   task automatic t_irq();
      acc(1'b1, `RTCR_IDX_TOP_H, 8'h00);
      acc(1'b1, `RTCR_IDX_TOP_L, 8'h03);
      // Each slot is looked at right after its own write, before two ticks pass
      acc(1'b0, `RTCR_IDX_STATUS, 8'h00);
      chk8("top busy", 8'h04, rv & 8'h04);
      acc(1'b1, `RTCR_IDX_CMP_H, 8'h00);
      acc(1'b1, `RTCR_IDX_CMP_L, 8'h02);
      acc(1'b0, `RTCR_IDX_STATUS, 8'h00);
      chk8("compare busy", 8'h08, rv & 8'h08);
      acc(1'b1, `RTCR_IDX_CNT_H, 8'h00);
      acc(1'b1, `RTCR_IDX_CNT_L, 8'h00);
      acc(1'b0, `RTCR_IDX_STATUS, 8'h00);
      chk8("count busy", 8'h02, rv & 8'h02);
      wait_idle(8'h0E);
      acc(1'b0, `RTCR_IDX_TOP_L, 8'h00);
      chk8("top low", 8'h03, rv);
      acc(1'b1, `RTCR_IDX_CTRL, 8'h01);
      wait_idle(8'h01);
      repeat (100) @(posedge clk_i);
      chk8("irq masked", 8'h00, {7'h00, irq_o});
      acc(1'b1, `RTCR_IDX_CTRL, 8'h00);
      wait_idle(8'h01);
      acc(1'b0, `RTCR_IDX_IRQFL, 8'h00);
      chk8("flags", 8'h03, rv);
      acc(1'b1, `RTCR_IDX_IRQEN, 8'h01);
      chk8("irq wrap", 8'h01, {7'h00, irq_o});
      acc(1'b1, `RTCR_IDX_IRQFL, 8'h01);
      chk8("irq after clear", 8'h00, {7'h00, irq_o});
      acc(1'b1, `RTCR_IDX_IRQEN, 8'h02);
      chk8("irq compare", 8'h01, {7'h00, irq_o});
      acc(1'b1, `RTCR_IDX_IRQFL, 8'h00);
      acc(1'b0, `RTCR_IDX_IRQFL, 8'h00);
      chk8("flags", 8'h02, rv);
      acc(1'b1, `RTCR_IDX_IRQFL, 8'h02);
      chk8("irq after clear", 8'h00, {7'h00, irq_o});
      $display("t_irq done");
   endtask : t_irq

   // Periodic timer alone keeps the prescaler running and raises its request
   task automatic t_pit();
      acc(1'b1, `RTCR_IDX_PIRQEN, 8'h01);
      acc(1'b1, `RTCR_IDX_PCTRL, 8'h09);
      repeat (64) @(posedge clk_i);
      chk8("pit irq", 8'h01, {7'h00, pit_irq_o});
      acc(1'b1, `RTCR_IDX_PCTRL, 8'h00);
      acc(1'b1, `RTCR_IDX_PIRQFL, 8'h01);
      chk8("pit irq after clear", 8'h00, {7'h00, pit_irq_o});
      $display("t_pit done");
   endtask : t_pit

   // Main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_ctrl();
      measure(8'h01, 1'b0, 16'd32);
      measure(8'h09, 1'b0, 16'd16);
      measure(8'h19, 1'b0, 16'd4);
      measure(8'h00, 1'b0, 16'd0);
      measure(8'h01, 1'b1, 16'd0);
      measure(8'h85, 1'b1, 16'd32);
      // Large skip count swallows every tick of the short window
      acc(1'b1, `RTCR_IDX_CRYSTAL_CALIBRATION, 8'h7F);
      measure(8'h85, 1'b0, 16'd0);
      measure(8'h00, 1'b0, 16'd0);
      t_irq();
      t_pit();
      conclude();
   end
endmodule : test_rtcr_top
